// *** design/fpmi_decoder.sv ***
// Wishbone-attached decoder and executor for mantissa and integer-part ops
`include "fpmi_params.svh"
`default_nettype none

module fpmi_decoder
	import fpmi_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	fpmi_state_t state_r;
	fpmi_dec_t dec_r;
	fpmi_dec_t decNow;
	fpmi_ext_t srcOp_r;
	fpmi_ext_t srcFromReg;
	fpmi_ext_t unitRes;
	fpmi_exc_t unitExc;
	fpmi_ext_t fpReg [8];
	fpmi_rnd_t rnd;
	logic [31:0] instr_r;
	logic [31:0] ctrl_r;
	logic [31:0] stat_r;
	logic [31:0] stat_nxt;
	logic [31:0] opMhi_r;
	logic [31:0] opMlo_r;
	logic [16:0] opExp_r;
	logic [31:0] rdData;
	logic [2:0] cmdIdx;
	logic srcInex_r;
	logic execd_r;
	logic reqWr;
	logic reqRd;
	logic cmdWr;
	logic idle;
	logic execWr;
	logic inexact_decimal_input_flag;
	logic statWr;

	//------------------------------
	// Helper functions
	//------------------------------

	// Byte-lane merge for Wishbone writes
	function automatic logic [31:0] fpmiMerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Two-word instruction decode
	function automatic fpmi_dec_t fpmiDecode(input logic [31:0] ins, input logic [2:0] id);
		fpmi_dec_t d;
		logic [15:0] w0;
		logic [15:0] w1;
		logic fmtOk;
		logic eaOk;
		w0 = ins[31:16];
		w1 = ins[15:0];
		d = '0;
		d.selected = w0[15:12] == `FPMI_W0_LINE && w0[11:9] == id && w0[8:6] == 3'h0;
		d.regMem = w1[14];
		d.srcSpec = w1[12:10];
		d.dstReg = w1[9:7];
		d.eaMode = w0[5:3];
		d.eaReg = w0[2:0];
		case (w1[6:0])
			`FPMI_OPC_MANT: d.op = FPMI_OP_MANT;
			`FPMI_OPC_INT: d.op = FPMI_OP_INT;
			default: d.op = FPMI_OP_NONE;
		endcase
		fmtOk = !d.regMem || d.srcSpec != `FPMI_FMT_BAD;
		case (d.eaMode)
			`FPMI_EA_DN: eaOk = d.srcSpec == `FPMI_FMT_L || d.srcSpec == `FPMI_FMT_S ||
				d.srcSpec == `FPMI_FMT_W || d.srcSpec == `FPMI_FMT_B;
			`FPMI_EA_AN: eaOk = 1'b0;
			`FPMI_EA_EXT: eaOk = d.eaReg <= `FPMI_EA_IMM;
			default: eaOk = 1'b1;
		endcase
		if (!d.regMem) begin
			eaOk = 1'b1;
		end
		d.legal = !w1[15] && !w1[13] && d.op != FPMI_OP_NONE && fmtOk && eaOk;
		return d;
	endfunction

	//------------------------------
	// Bus decode
	//------------------------------

	// One request per handshake; the ack cycle itself is not a new request
	assign reqWr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
	assign reqRd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
	assign cmdWr = reqWr && wb_adr_i == `FPMI_ADR_CMD && wb_sel_i[0] && state_r == ST_IDLE;
	assign statWr = reqWr && wb_adr_i == `FPMI_ADR_STAT;
	assign cmdIdx = wb_dat_i[`FPMI_CMD_IDX_LSB +: 3];
	assign idle = state_r == ST_IDLE;
	assign rnd = fpmi_rnd_t'(ctrl_r[`FPMI_CTRL_RND_LSB +: 2]);
	assign decNow = fpmiDecode(instr_r, ctrl_r[`FPMI_CTRL_ID_LSB +: 3]);
	assign srcFromReg = fpReg[decNow.srcSpec];
	assign execWr = state_r == ST_EXEC && dec_r.selected && dec_r.legal;
	assign inexact_decimal_input_flag = dec_r.regMem && dec_r.srcSpec == `FPMI_FMT_P && srcInex_r;

	//------------------------------
	// Arithmetic unit
	//------------------------------
	fpmi_ext_unit u_unit (
		.op(dec_r.op),
		.rnd(rnd),
		.src(srcOp_r),
		.res(unitRes),
		.exc(unitExc)
	);

	//------------------------------
	// Wishbone answer
	//------------------------------

	// Read data mux
	always_comb begin
		rdData = 32'h0000_0000;
		case (wb_adr_i)
			`FPMI_ADR_INSTR: rdData = instr_r;
			`FPMI_ADR_CTRL: rdData = ctrl_r;
			`FPMI_ADR_STAT: rdData = stat_r;
			`FPMI_ADR_OPEXP: rdData = {15'h0, opExp_r};
			`FPMI_ADR_OPMHI: rdData = opMhi_r;
			`FPMI_ADR_OPMLO: rdData = opMlo_r;
			`FPMI_ADR_CMD: rdData = {31'h0, ~idle};
			`FPMI_ADR_DEC: rdData = {14'h0, execd_r, dec_r};
			default: rdData = 32'h0000_0000; // Unmapped reads as zero
		endcase
	end

	// Ack one cycle after the request, every address answered
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
		end
	end

	// Read data register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (reqRd) begin
			wb_dat_o <= rdData;
		end
	end

	//------------------------------
	// Software registers
	//------------------------------

	// Instruction words and control register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			instr_r <= 32'h0000_0000;
			ctrl_r <= `FPMI_CTRL_RST;
		end else if (reqWr) begin
			if (wb_adr_i == `FPMI_ADR_INSTR) begin
				instr_r <= fpmiMerge(instr_r, wb_dat_i, wb_sel_i);
			end
			if (wb_adr_i == `FPMI_ADR_CTRL) begin
				ctrl_r <= fpmiMerge(ctrl_r, wb_dat_i, wb_sel_i);
			end
		end
	end

	// Operand staging, also filled from a data register by the store command
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			opExp_r <= 17'h0;
			opMhi_r <= 32'h0000_0000;
			opMlo_r <= 32'h0000_0000;
		end else if (cmdWr && wb_dat_i[`FPMI_CMD_STORE_BIT]) begin
			opExp_r <= {1'b0, fpReg[cmdIdx].sign, fpReg[cmdIdx].exp};
			opMhi_r <= fpReg[cmdIdx].mant[63:32];
			opMlo_r <= fpReg[cmdIdx].mant[31:0];
		end else if (reqWr) begin
			if (wb_adr_i == `FPMI_ADR_OPEXP) begin
				opExp_r <= 17'(fpmiMerge({15'h0, opExp_r}, wb_dat_i, wb_sel_i));
			end
			if (wb_adr_i == `FPMI_ADR_OPMHI) begin
				opMhi_r <= fpmiMerge(opMhi_r, wb_dat_i, wb_sel_i);
			end
			if (wb_adr_i == `FPMI_ADR_OPMLO) begin
				opMlo_r <= fpmiMerge(opMlo_r, wb_dat_i, wb_sel_i);
			end
		end
	end

	//------------------------------
	// Sequencer
	//------------------------------

	// Idle, decode and fetch, execute and write back
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (cmdWr && wb_dat_i[`FPMI_CMD_EXEC_BIT]) begin
						state_r <= ST_DECODE;
					end
				end
				ST_DECODE: state_r <= ST_EXEC;
				ST_EXEC: state_r <= ST_IDLE;
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Latch decode and source operand
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dec_r <= '0;
			srcOp_r <= '0;
			srcInex_r <= 1'b0;
		end else if (state_r == ST_DECODE) begin
			dec_r <= decNow;
			srcInex_r <= opExp_r[`FPMI_OPEXP_DECINEX_BIT];
			if (decNow.regMem) begin
				srcOp_r <= {opExp_r[15:0], opMhi_r, opMlo_r};
			end else begin
				srcOp_r <= srcFromReg;
			end
		end
	end

	// Done flag shows the last instruction actually ran
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			execd_r <= 1'b0;
		end else if (state_r == ST_EXEC) begin
			execd_r <= execWr;
		end
	end

	// Data registers: result write back, or load from staging
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < 8; i++) begin
				fpReg[i] <= '0;
			end
		end else if (execWr) begin
			fpReg[dec_r.dstReg] <= unitRes;
		end else if (cmdWr && wb_dat_i[`FPMI_CMD_LOAD_BIT]) begin
			fpReg[cmdIdx] <= {opExp_r[15:0], opMhi_r, opMlo_r};
		end
	end

	//------------------------------
	// Status register
	//------------------------------

	// Execution flags win over a same-cycle software write
	always_comb begin
		stat_nxt = stat_r;
		if (statWr) begin
			stat_nxt = fpmiMerge(stat_r, wb_dat_i, wb_sel_i);
		end
		if (execWr) begin
			stat_nxt[`FPMI_CC_N] = unitRes.sign;
			stat_nxt[`FPMI_CC_Z] = fpmiIsZero(unitRes);
			stat_nxt[`FPMI_CC_I] = fpmiIsInf(unitRes);
			stat_nxt[`FPMI_CC_NAN] = fpmiIsNan(unitRes);
			stat_nxt[`FPMI_EXC_LSB +: 8] = {1'b0, unitExc.signaling_nan_flag, unitExc.operand_error_flag, 3'h0,
				unitExc.inexact_operation_flag, inexact_decimal_input_flag};
			stat_nxt[`FPMI_ACC_IOP] = stat_nxt[`FPMI_ACC_IOP] | unitExc.signaling_nan_flag | unitExc.operand_error_flag;
			stat_nxt[`FPMI_ACC_INEX] = stat_nxt[`FPMI_ACC_INEX] | unitExc.inexact_operation_flag | inexact_decimal_input_flag;
		end
	end

	// Quotient byte follows software only
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stat_r <= `FPMI_STAT_RST;
		end else begin
			stat_r <= stat_nxt;
		end
	end

	//------------------------------
	// Assertions
	//------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_unsel_nowrite: assert property (state_r == ST_EXEC && !dec_r.selected |=> !execd_r)
		else $error("unselected instruction executed");
	a_rm_srcreg: assert property (state_r == ST_DECODE && !decNow.regMem |=> srcOp_r == $past(srcFromReg))
		else $error("register source not taken from data register");
	a_an_refused: assert property (state_r == ST_DECODE && decNow.regMem && decNow.eaMode == `FPMI_EA_AN
		|=> !dec_r.legal ##1 !execd_r)
		else $error("address register source accepted");
	a_mant_range: assert property (execWr && dec_r.op == FPMI_OP_MANT && !fpmiIsZero(srcOp_r) &&
		!fpmiIsInf(srcOp_r) && !fpmiIsNan(srcOp_r)
		|-> unitRes.exp == `FPMI_EXP_BIAS && unitRes.mant[63] && unitRes.sign == srcOp_r.sign)
		else $error("mantissa outside one to two");
	a_inf_operand_error_flag: assert property (execWr && dec_r.op == FPMI_OP_MANT && fpmiIsInf(srcOp_r)
		|=> stat_r[`FPMI_EXC_OPERAND_ERROR_FLAG] && stat_r[`FPMI_ACC_IOP])
		else $error("infinite mantissa source without operand error");
	a_quot_kept: assert property (execWr && !statWr |=> $stable(stat_r[23:16]))
		else $error("quotient byte changed by operation");
	a_acc_inex: assert property (execWr && unitExc.inexact_operation_flag
		|=> stat_r[`FPMI_ACC_INEX] && stat_r[`FPMI_EXC_INEXACT_OPERATION_FLAG])
		else $error("inexact not accrued");
	a_int_inf: assert property (execWr && dec_r.op == FPMI_OP_INT && fpmiIsInf(srcOp_r)
		|=> !stat_r[`FPMI_EXC_OPERAND_ERROR_FLAG] && stat_r[`FPMI_CC_I])
		else $error("infinite integer-part source mishandled");
	a_int_clear: assert property (execWr && dec_r.op == FPMI_OP_INT
		|=> !stat_r[`FPMI_EXC_BRANCH_UNORDERED_FLAG] && stat_r[13:10] == 4'h0)
		else $error("integer part left stale flags");
	a_exec_span: assert property (idle && cmdWr && wb_dat_i[`FPMI_CMD_EXEC_BIT]
		|=> state_r == ST_DECODE ##1 state_r == ST_EXEC ##1 idle)
		else $error("execution sequence broken");

	c_mant_run: cover property (execWr && dec_r.op == FPMI_OP_MANT);
	c_int_round: cover property (execWr && dec_r.op == FPMI_OP_INT && unitExc.inexact_operation_flag);
	c_illegal: cover property (state_r == ST_EXEC && dec_r.selected && !dec_r.legal);
	c_same_reg: cover property (execWr && !dec_r.regMem && dec_r.srcSpec == dec_r.dstReg);
endmodule // fpmi_decoder

`default_nettype wire

// *** design/fpmi_ext_unit.sv ***
// Combinational mantissa and integer-part arithmetic on extended operands
`include "fpmi_params.svh"
`default_nettype none

module fpmi_ext_unit
	import fpmi_pkg::*;
(
	input wire fpmi_op_t op,
	input wire fpmi_rnd_t rnd,
	input wire fpmi_ext_t src,
	output fpmi_ext_t res,
	output fpmi_exc_t exc
);
	//------------------------------
	// Result and flags
	//------------------------------
	always_comb begin
		logic [127:0] wide;
		logic [64:0] n;
		logic [6:0] lz;
		logic [6:0] sh;
		logic grd;
		logic stk;
		logic inc;
		wide = 128'h0;
		n = 65'h0;
		lz = 7'h0;
		sh = 7'h0;
		grd = 1'b0;
		stk = 1'b0;
		inc = 1'b0;
		res = src;
		exc = '0;
		if (fpmiIsNan(src)) begin
			res.mant[62] = 1'b1;
			exc.signaling_nan_flag = ~src.mant[62];
		end else if (fpmiIsZero(src)) begin
			res = {src.sign, 15'h0, 64'h0};
		end else if (op == FPMI_OP_MANT) begin
			if (fpmiIsInf(src)) begin
				res = {1'b0, `FPMI_EXP_MAX, `FPMI_NAN_MANT};
				exc.operand_error_flag = 1'b1;
			end else begin
				lz = fpmiLzc(src.mant);
				res.exp = `FPMI_EXP_BIAS;
				res.mant = src.mant << lz;
			end
		end else if (!fpmiIsInf(src) && src.exp < `FPMI_EXP_INTMIN) begin
			// Split at the binary point; below one half only sticky survives
			if (src.exp < `FPMI_EXP_BIAS - 15'h1) begin
				stk = 1'b1;
			end else begin
				sh = 7'(`FPMI_EXP_INTMIN - src.exp);
				wide = {src.mant, 64'h0} >> sh;
				n = {1'b0, wide[127:64]};
				grd = wide[63];
				stk = |wide[62:0];
			end
			case (rnd)
				FPMI_RN: inc = grd & (stk | n[0]);
				FPMI_RM: inc = src.sign & (grd | stk);
				FPMI_RP: inc = ~src.sign & (grd | stk);
				default: inc = 1'b0;
			endcase
			n = n + {64'h0, inc};
			exc.inexact_operation_flag = grd | stk;
			if (n == 65'h0) begin
				res = {src.sign, 15'h0, 64'h0};
			end else if (n[64]) begin
				res = {src.sign, 15'(`FPMI_EXP_INTMIN + 15'h1), `FPMI_MANT_ONE};
			end else begin
				lz = fpmiLzc(n[63:0]);
				res.exp = 15'(`FPMI_EXP_INTMIN - {8'h0, lz});
				res.mant = n[63:0] << lz;
			end
		end
	end
endmodule // fpmi_ext_unit

`default_nettype wire

// *** design/fpmi_params.svh ***
// Constants for the mantissa-extract and integer-part decoder
//------------------------------------------------------------
//------------------------------------------------------------
`ifndef FPMI_PARAMS_SVH
`define FPMI_PARAMS_SVH
`define FPMI_ADR_INSTR 8'h00
`define FPMI_ADR_CTRL 8'h04
`define FPMI_ADR_STAT 8'h08
`define FPMI_ADR_OPEXP 8'h0C
`define FPMI_ADR_OPMHI 8'h10
`define FPMI_ADR_OPMLO 8'h14
`define FPMI_ADR_CMD 8'h18
`define FPMI_ADR_DEC 8'h1C
`define FPMI_CTRL_RND_LSB 4
`define FPMI_CTRL_ID_LSB 16
`define FPMI_CTRL_RST 32'h0001_0000
`define FPMI_STAT_RST 32'h0000_0000
`define FPMI_CMD_EXEC_BIT 0
`define FPMI_CMD_LOAD_BIT 1
`define FPMI_CMD_STORE_BIT 2
`define FPMI_CMD_IDX_LSB 8
`define FPMI_OPEXP_DECINEX_BIT 16
`define FPMI_DEC_DONE_BIT 17
`define FPMI_CC_N 27
`define FPMI_CC_Z 26
`define FPMI_CC_I 25
`define FPMI_CC_NAN 24
`define FPMI_QUOT_LSB 16
`define FPMI_EXC_LSB 8
`define FPMI_EXC_BRANCH_UNORDERED_FLAG 15
`define FPMI_EXC_OPERAND_ERROR_FLAG 13
`define FPMI_EXC_INEXACT_OPERATION_FLAG 9
`define FPMI_ACC_IOP 7
`define FPMI_ACC_INEX 3
`define FPMI_W0_LINE 4'hF
`define FPMI_OPC_MANT 7'h1F
`define FPMI_OPC_INT 7'h01
`define FPMI_FMT_L 3'h0
`define FPMI_FMT_S 3'h1
`define FPMI_FMT_P 3'h3
`define FPMI_FMT_W 3'h4
`define FPMI_FMT_B 3'h6
`define FPMI_FMT_BAD 3'h7
`define FPMI_EA_DN 3'h0
`define FPMI_EA_AN 3'h1
`define FPMI_EA_EXT 3'h7
`define FPMI_EA_IMM 3'h4
`define FPMI_EXP_BIAS 15'h3FFF
`define FPMI_EXP_MAX 15'h7FFF
`define FPMI_EXP_INTMIN 15'h403E
`define FPMI_NAN_MANT 64'hFFFF_FFFF_FFFF_FFFF
`define FPMI_MANT_ONE 64'h8000_0000_0000_0000
`endif

// *** design/fpmi_pkg.sv ***
// Types and classification helpers for the mantissa and integer-part block
`default_nettype none

package fpmi_pkg;
	typedef struct packed {
		logic sign;
		logic [14:0] exp;
		logic [63:0] mant;
	} fpmi_ext_t;

	typedef enum logic [1:0] {FPMI_RN = 2'h0, FPMI_RZ = 2'h1, FPMI_RM = 2'h2, FPMI_RP = 2'h3} fpmi_rnd_t;
	typedef enum logic [1:0] {FPMI_OP_NONE = 2'h0, FPMI_OP_MANT = 2'h1, FPMI_OP_INT = 2'h2} fpmi_op_t;
	typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_DECODE = 3'h2, ST_EXEC = 3'h4} fpmi_state_t;

	typedef struct packed {
		logic selected;
		logic legal;
		fpmi_op_t op;
		logic regMem;
		logic [2:0] srcSpec;
		logic [2:0] dstReg;
		logic [2:0] eaMode;
		logic [2:0] eaReg;
	} fpmi_dec_t;

	typedef struct packed {
		logic signaling_nan_flag;
		logic operand_error_flag;
		logic inexact_operation_flag;
	} fpmi_exc_t;

	function automatic logic fpmiIsNan(input fpmi_ext_t v);
		return v.exp == 15'h7FFF && v.mant[62:0] != 63'h0;
	endfunction

	function automatic logic fpmiIsInf(input fpmi_ext_t v);
		return v.exp == 15'h7FFF && v.mant[62:0] == 63'h0;
	endfunction

	function automatic logic fpmiIsZero(input fpmi_ext_t v);
		return v.exp != 15'h7FFF && v.mant == 64'h0;
	endfunction

	// Leading zero count, 64 for an all-zero word
	function automatic logic [6:0] fpmiLzc(input logic [63:0] v);
		logic [6:0] n;
		logic found;
		n = 7'h40;
		found = 1'b0;
		for (int i = 63; i >= 0; i--) begin
			if (!found && v[i]) begin
				n = 7'(63 - i);
				found = 1'b1;
			end
		end
		return n;
	endfunction
endpackage

`default_nettype wire

// *** tb/fp_mantissa_integer_ops_tb.sv ***
// Self-checking bench for the mantissa and integer-part decoder
`include "fpmi_params.svh"
`default_nettype none

module fp_mantissa_integer_ops_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic wbCyc, wbStb, wbWe, wbAck;
	logic [7:0] wbAdr;
	logic [3:0] wbSel;
	logic [31:0] wbDatW, wbDatR, rdVal;
	int n_mismatch = 0;
	int n_compared = 0;
	int cycles = 0;

	//------------------------------------------------
	// Clock, design and host model
	//------------------------------------------------
	always #5 clk = ~clk;

	fpmi_decoder u_dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
		.wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck));

	fpmi_host_model u_host (.clk(clk), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
		.wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck));

	//------------------------------------------------
	// Shared helpers
	//------------------------------------------------
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			end_sim();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_host.wbCycle(1'b1, a, d, rdVal);
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		u_host.wbCycle(1'b0, a, 32'h0000_0000, rdVal);
		check(rdVal & m, exp);
	endtask

	// Polls busy with a bounded count
	task automatic waitIdle();
		int n;
		n = 0;
		do begin
			u_host.wbCycle(1'b0, `FPMI_ADR_CMD, 32'h0000_0000, rdVal);
			n++;
		end while (rdVal[0] !== 1'b0 && n < 20);
		check({31'h0, rdVal[0]}, 32'h0000_0000);
	endtask

	task automatic load(input logic [2:0] idx, input logic [31:0] e, input logic [31:0] hi, input logic [31:0] lo);
		wr(`FPMI_ADR_OPEXP, e);
		wr(`FPMI_ADR_OPMHI, hi);
		wr(`FPMI_ADR_OPMLO, lo);
		wr(`FPMI_ADR_CMD, {21'h0, idx, 8'h02});
		waitIdle();
	endtask

	// Quotient preset to AB so any disturbance shows
	task automatic run(input logic [31:0] instr);
		wr(`FPMI_ADR_STAT, 32'h00AB_0000);
		wr(`FPMI_ADR_INSTR, instr);
		wr(`FPMI_ADR_CMD, 32'h0000_0001);
		waitIdle();
	endtask

	task automatic result(input logic [2:0] idx, input logic [15:0] e, input logic [31:0] hi, input logic [31:0] lo);
		wr(`FPMI_ADR_CMD, {21'h0, idx, 8'h04});
		waitIdle();
		rdChk(`FPMI_ADR_OPEXP, 32'h0000_FFFF, {16'h0000, e});
		rdChk(`FPMI_ADR_OPMHI, 32'hFFFF_FFFF, hi);
		rdChk(`FPMI_ADR_OPMLO, 32'hFFFF_FFFF, lo);
	endtask

	//------------------------------------------------
	// Scenarios
	//------------------------------------------------
	task automatic tResetMap();
		rdChk(`FPMI_ADR_CTRL, 32'hFFFF_FFFF, 32'h0001_0000);
		rdChk(`FPMI_ADR_STAT, 32'hFFFF_FFFF, 32'h0000_0000);
		rdChk(8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
	endtask

	// Mantissa of -137.5 in place, and of -0
	task automatic tMantissa();
		load(3'h2, 32'h0000_C006, 32'h8980_0000, 32'h0000_0000);
		run(u_host.mkInstr(3'h1, 1'b0, 6'h3F, 3'h2, 3'h2, `FPMI_OPC_MANT));
		rdChk(`FPMI_ADR_STAT, 32'h00FF_FFFF, 32'h00AB_0000);
		result(3'h2, 16'hBFFF, 32'h8980_0000, 32'h0000_0000);
		load(3'h3, 32'h0000_8000, 32'h0000_0000, 32'h0000_0000);
		run(u_host.mkInstr(3'h1, 1'b0, 6'h00, 3'h3, 3'h4, `FPMI_OPC_MANT));
		result(3'h4, 16'h8000, 32'h0000_0000, 32'h0000_0000);
	endtask

	task automatic tMantInf();
		load(3'h1, 32'h0000_7FFF, 32'h8000_0000, 32'h0000_0000);
		run(u_host.mkInstr(3'h1, 1'b0, 6'h00, 3'h1, 3'h6, `FPMI_OPC_MANT));
		rdChk(`FPMI_ADR_STAT, 32'h00FF_FFFF, 32'h00AB_2080);
		result(3'h6, 16'h7FFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
		// Signaling NAN in place comes back quiet with the signaling flag
		load(3'h1, 32'h0000_7FFF, 32'h8000_0000, 32'h0000_0001);
		run(u_host.mkInstr(3'h1, 1'b0, 6'h00, 3'h1, 3'h1, `FPMI_OPC_MANT));
		rdChk(`FPMI_ADR_STAT, 32'h00FF_FFFF, 32'h00AB_4080);
		result(3'h1, 16'h7FFF, 32'hC000_0000, 32'h0000_0001);
	endtask

	// 137.5 under every rounding mode, then -inf
	task automatic tIntModes();
		for (int r = 0; r < 4; r++) begin
			wr(`FPMI_ADR_CTRL, 32'h0001_0000 | (32'(r) << 4));
			load(3'h0, 32'h0000_4006, 32'h8980_0000, 32'h0000_0000);
			run(u_host.mkInstr(3'h1, 1'b0, 6'h00, 3'h0, 3'h7, `FPMI_OPC_INT));
			rdChk(`FPMI_ADR_STAT, 32'h00FF_FFFF, 32'h00AB_0208);
			result(3'h7, 16'h4006, (r == 0 || r == 3) ? 32'h8A00_0000 : 32'h8900_0000, 32'h0000_0000);
		end
		// -137.5 toward minus infinity gives -138
		wr(`FPMI_ADR_CTRL, 32'h0001_0020);
		load(3'h0, 32'h0000_C006, 32'h8980_0000, 32'h0000_0000);
		run(u_host.mkInstr(3'h1, 1'b0, 6'h00, 3'h0, 3'h3, `FPMI_OPC_INT));
		result(3'h3, 16'hC006, 32'h8A00_0000, 32'h0000_0000);
		load(3'h1, 32'h0000_FFFF, 32'h8000_0000, 32'h0000_0000);
		run(u_host.mkInstr(3'h1, 1'b0, 6'h00, 3'h1, 3'h3, `FPMI_OPC_INT));
		rdChk(`FPMI_ADR_STAT, 32'h00FF_FFFF, 32'h00AB_0000);
		result(3'h3, 16'hFFFF, 32'h8000_0000, 32'h0000_0000);
	endtask

	// Packed immediate source with decimal hint, staged operand
	task automatic tMemForm();
		wr(`FPMI_ADR_CTRL, 32'h0001_0000);
		wr(`FPMI_ADR_OPEXP, 32'h0001_4006);
		wr(`FPMI_ADR_OPMHI, 32'h8980_0000);
		wr(`FPMI_ADR_OPMLO, 32'h0000_0000);
		run(u_host.mkInstr(3'h1, 1'b1, 6'h3C, 3'h3, 3'h5, `FPMI_OPC_INT));
		rdChk(`FPMI_ADR_DEC, 32'hFFFF_FFFF, 32'h0003_D77C);
		rdChk(`FPMI_ADR_STAT, 32'h00FF_FFFF, 32'h00AB_0308);
		result(3'h5, 16'h4006, 32'h8A00_0000, 32'h0000_0000);
	endtask

	// Wrong id, then data/address register sources by format
	task automatic tRefused();
		run(u_host.mkInstr(3'h2, 1'b0, 6'h00, 3'h0, 3'h7, `FPMI_OPC_INT));
		rdChk(`FPMI_ADR_DEC, 32'h0003_0000, 32'h0000_0000);
		result(3'h7, 16'h4006, 32'h8A00_0000, 32'h0000_0000);
		run(u_host.mkInstr(3'h1, 1'b1, 6'h00, 3'h2, 3'h6, `FPMI_OPC_INT));
		rdChk(`FPMI_ADR_DEC, 32'h0000_8000, 32'h0000_0000);
		run(u_host.mkInstr(3'h1, 1'b1, 6'h09, 3'h0, 3'h6, `FPMI_OPC_INT));
		rdChk(`FPMI_ADR_DEC, 32'h0000_8000, 32'h0000_0000);
		run(u_host.mkInstr(3'h1, 1'b1, 6'h01, 3'h1, 3'h6, `FPMI_OPC_INT));
		rdChk(`FPMI_ADR_DEC, 32'h0000_8000, 32'h0000_8000);
	endtask

	//------------------------------------------------
	// Main sequence
	//------------------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		tResetMap();
		tMantissa();
		tMantInf();
		tIntModes();
		tMemForm();
		tRefused();
		end_sim();
	end
endmodule // fp_mantissa_integer_ops_tb

`default_nettype wire

// *** tb/fpmi_host_model.sv ***
// Host model: issues coprocessor instructions and classic Wishbone cycles
`include "fpmi_params.svh"
`default_nettype none

module fpmi_host_model (
	input wire logic clk,
	output logic wbCyc,
	output logic wbStb,
	output logic wbWe,
	output logic [7:0] wbAdr,
	output logic [3:0] wbSel,
	output logic [31:0] wbDatW,
	input wire logic [31:0] wbDatR,
	input wire logic wbAck
);
	timeunit 1ns;
	timeprecision 1ps;

	//------------------------------------------------
	// Bus idle values at time zero
	//------------------------------------------------
	initial begin
		wbCyc = 1'b0;
		wbStb = 1'b0;
		wbWe = 1'b0;
		wbAdr = 8'h00;
		wbSel = 4'h0;
		wbDatW = 32'h0000_0000;
	end

	// One single cycle; request held until ack is sampled high
	task automatic wbCycle(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= a;
		wbSel <= 4'hF;
		wbDatW <= d;
		// No cycle limit here; the bench's hang guard ends a stuck wait
		do begin
			@(posedge clk);
		end while (wbAck !== 1'b1);
		q = wbDatR;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe <= 1'b0;
		wbDatW <= ~d; // Released bus never shows the stale value
	endtask

	// Builds the two instruction words; ea field zeroed for register forms
	function automatic logic [31:0] mkInstr(input logic [2:0] id, input logic rm, input logic [5:0] ea,
		input logic [2:0] spec, input logic [2:0] dst, input logic [6:0] opc);
		return {4'hF, id, 3'h0, rm ? ea : 6'h00, 1'b0, rm, 1'b0, spec, dst, opc};
	endfunction
endmodule // fpmi_host_model

`default_nettype wire
